// ### rss_consts.svh
// Purpose: Constants for the rotate/set/sleep execution block
// Assumes: 16-bit instruction words, 8-bit data, 12-bit data address
// Notes:   Definitions only; included by bare name
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// ==========================================================
// Opcode patterns
`define RSS_ROT_MASK      16'hFC00
`define RSS_ROT_PAT       16'h4000
`define RSS_FILL_MASK     16'hFE00
`define RSS_FILL_PAT      16'h6800
`define RSS_SLEEP_CODE    16'h0003

// ==========================================================
// Field positions inside the instruction word
`define RSS_DEST_BIT      9
`define RSS_BANK_BIT      8
`define RSS_FILE_MSB      7

// ==========================================================
// Addressing limits and fill values
`define RSS_IDX_LIMIT     8'h5F
`define RSS_ACC_HI_BANK   4'hF
`define RSS_ACC_LO_BANK   4'h0
`define RSS_ALL_ONES      8'hFF

// ==========================================================
// Reset values of the status bits (both read 1 after power-up)
`define RSS_TMOUT_RESET   1'b1
`define RSS_PWRDN_RESET   1'b1

`endif

// ### rss_datapath.sv
// Purpose: Address formation and rotate arithmetic
// Assumes: Purely combinational, used by rss_exec
// Notes:   Indexed mode adds the file field to the index pointer
`timescale 1ns/100ps
`include "rss_consts.svh"

module rss_datapath (
  input  wire logic [15:0] instr,         // Instruction word
  input  wire logic        ext_set_en,    // Extended set enabled
  input  wire logic [3:0]  bank_select_reg, // Bank select register
  input  wire logic [11:0] index_ptr,     // Base for indexed mode
  input  wire logic [7:0]  operand,       // Byte read from file space
  output logic      [11:0] eff_addr,      // Effective data address
  output logic             indexed,       // Indexed mode in use
  output logic      [7:0]  rot_result     // Rotated operand
);

  // Rotate one place right, bit 0 wraps into bit 7, carry unused
  function automatic logic [7:0] rss_ror(input logic [7:0] v);
    rss_ror = {v[0], v[7:1]};
  endfunction : rss_ror

  logic [7:0] ffield;   // File address field
  logic       abit;     // Bank bit

  // ==========================================================
  // Address selection
  always_comb begin
    ffield  = instr[`RSS_FILE_MSB:0];
    abit    = instr[`RSS_BANK_BIT];
    indexed = ext_set_en && !abit && (ffield <= `RSS_IDX_LIMIT);
    if (indexed) begin
      // Sum wraps inside the 12-bit data space
      eff_addr = index_ptr + {4'h0, ffield};
    end else if (!abit) begin
      // Access bank, pointer register ignored
      eff_addr = (ffield <= `RSS_IDX_LIMIT) ?
                 {`RSS_ACC_LO_BANK, ffield} : {`RSS_ACC_HI_BANK, ffield};
    end else begin
      // Bank chosen by the bank select register
      eff_addr = {bank_select_reg, ffield};
    end
    rot_result = rss_ror(operand);
  end

endmodule : rss_datapath

// ### rss_exec.sv
// Purpose: Executes rotate-right-no-carry, set-file and sleep
// Assumes: File space read is asynchronous on file_addr
// Notes:   Two clocks per instruction: address, then result
`timescale 1ns/100ps
`include "rss_consts.svh"

// Overview of operation
// - Decode rotate opcode with destination, bank, address
// - Rotate right, bit zero wraps, no carry
// - Destination bit picks working or file register
// - Bank bit zero selects access bank
// - Indexed mode: extended, bank zero, address<=95
// - Set-file writes all ones, flags untouched
// - Set-file bank bit selects bank or access
// - Sleep clears power-down bit, sets time-out bit
// - Sleep clears watchdog count and postscaler
// - After sleep, core sleeps with oscillator stopped
// - Watchdog wake-up clears the time-out bit
module rss_exec (
  input  wire logic        mclk,             // 50 MHz core clock
  input  wire logic        rst,              // Async reset, high
  input  wire logic        instr_valid,      // Instruction offered
  input  wire logic [15:0] instr,            // Instruction word
  input  wire logic        ext_set_en,       // Extended set enabled
  input  wire logic [3:0]  bank_select_reg,  // Bank select register
  input  wire logic [11:0] index_ptr,        // Indexed-mode base
  input  wire logic [7:0]  file_rdata,       // Byte at file_addr
  input  wire logic        wake_wdt,         // Watchdog wake event
  input  wire logic        wake_other,       // Any other wake event
  output logic             instr_ready,      // May take instruction
  output logic      [11:0] file_addr,        // File space address
  output logic             file_we,          // File write pulse
  output logic      [7:0]  file_wdata,       // File write data
  output logic             w_we,             // Working reg write
  output logic      [7:0]  w_wdata,          // Working reg data
  output logic             indexed_mode,     // Indexed addressing
  output logic             flag_we,          // N/Z update pulse
  output logic             flag_n,           // Negative flag
  output logic             flag_z,           // Zero flag
  output logic             wdt_clear,        // Clear watchdog count
  output logic             wdt_post_clear,   // Clear postscaler
  output logic             timeout_status_bit,    // Time-out bit
  output logic             power_down_status_bit, // Power-down bit
  output logic             sleep_mode,       // Asleep, osc stopped
  output logic             instr_done,       // Completion pulse
  output logic             instr_unknown     // Opcode not handled
);
  import rss_pkg::*;

  // ==========================================================
  // State
  rss_state_t  state, next_state;         // Sequencer
  rss_op_t     op, next_op;               // Op in flight
  logic [15:0] ir, next_ir;               // Latched instruction
  logic [11:0] next_file_addr;            // Next address
  logic        next_instr_ready;          // Next ready
  logic        next_file_we;              // Next file write
  logic [7:0]  next_file_wdata;           // Next file data
  logic        next_w_we;                 // Next W write
  logic [7:0]  next_w_wdata;              // Next W data
  logic        next_indexed_mode;         // Next indexed flag
  logic        next_flag_we;              // Next flag update
  logic        next_flag_n;               // Next N
  logic        next_flag_z;               // Next Z
  logic        next_wdt_clear;            // Next watchdog clear
  logic        next_wdt_post_clear;       // Next postscaler clear
  logic        next_timeout;              // Next time-out bit
  logic        next_power_down;           // Next power-down bit
  logic        next_sleep_mode;           // Next sleep output
  logic        next_instr_done;           // Next done pulse
  logic        next_instr_unknown;        // Next unknown pulse

  // Datapath results
  logic [11:0] dp_addr;                   // Effective address
  logic        dp_indexed;                // Indexed mode
  logic [7:0]  dp_rot;                    // Rotated byte

  // Decode the incoming word; one opcode maps to at most one op
  function automatic rss_op_t rss_decode(input logic [15:0] w);
    if ((w & `RSS_ROT_MASK) == `RSS_ROT_PAT) begin
      rss_decode = RSS_OP_ROT;
    end else if ((w & `RSS_FILL_MASK) == `RSS_FILL_PAT) begin
      rss_decode = RSS_OP_FILL;
    end else if (w == `RSS_SLEEP_CODE) begin
      rss_decode = RSS_OP_SLEEP;
    end else begin
      rss_decode = RSS_OP_NONE;
    end
  endfunction : rss_decode

  // ==========================================================
  // Address computed from the incoming word, rotate from the file read byte
  rss_datapath u_dp (
    .instr           (instr),
    .ext_set_en      (ext_set_en),
    .bank_select_reg (bank_select_reg),
    .index_ptr       (index_ptr),
    .operand         (file_rdata),
    .eff_addr        (dp_addr),
    .indexed         (dp_indexed),
    .rot_result      (dp_rot)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    // Hold by default, pulses fall back to zero
    next_state          = state;
    next_op             = op;
    next_ir             = ir;
    next_file_addr      = file_addr;
    next_indexed_mode   = indexed_mode;
    next_file_wdata     = file_wdata;
    next_w_wdata        = w_wdata;
    next_flag_n         = flag_n;
    next_flag_z         = flag_z;
    next_timeout        = timeout_status_bit;
    next_power_down     = power_down_status_bit;
    next_file_we        = 1'b0;
    next_w_we           = 1'b0;
    next_flag_we        = 1'b0;
    next_wdt_clear      = 1'b0;
    next_wdt_post_clear = 1'b0;
    next_instr_done     = 1'b0;
    next_instr_unknown  = 1'b0;
    case (state)
      RSS_IDLE: begin
        // Take the word and present its operand address
        if (instr_valid) begin
          next_ir           = instr;
          next_op           = rss_decode(instr);
          next_file_addr    = dp_addr;
          next_indexed_mode = dp_indexed;
          next_state        = RSS_EXEC;
        end
      end
      RSS_EXEC: begin
        // Operand is valid now; finish in this one step
        next_instr_done = 1'b1;
        next_state      = RSS_IDLE;
        case (op)
          RSS_OP_ROT: begin
            if (ir[`RSS_DEST_BIT]) begin
              next_file_we    = 1'b1;
              next_file_wdata = dp_rot;
            end else begin
              next_w_we    = 1'b1;
              next_w_wdata = dp_rot;
            end
            // Only N and Z follow the result
            next_flag_we = 1'b1;
            next_flag_n  = dp_rot[7];
            next_flag_z  = (dp_rot == 8'h00);
          end
          RSS_OP_FILL: begin
            // Fill with ones, no flag update
            next_file_we    = 1'b1;
            next_file_wdata = `RSS_ALL_ONES;
          end
          RSS_OP_SLEEP: begin
            next_power_down     = 1'b0;
            next_timeout        = 1'b1;
            next_wdt_clear      = 1'b1;
            next_wdt_post_clear = 1'b1;
            next_state          = RSS_SLEEP;
          end
          default: begin
            // Foreign opcode, left for other decoders
            next_instr_unknown = 1'b1;
          end
        endcase
      end
      RSS_SLEEP: begin
        // Watchdog wake takes priority so its mark is never lost
        if (wake_wdt) begin
          next_timeout = 1'b0;
          next_state   = RSS_IDLE;
        end else if (wake_other) begin
          next_state = RSS_IDLE;
        end
      end
      default: begin
        // Illegal one-hot code recovers to idle
        next_state = RSS_IDLE;
      end
    endcase
    next_instr_ready = (next_state == RSS_IDLE);
    next_sleep_mode  = (next_state == RSS_SLEEP);
  end

  // ==========================================================
  // Registers only; outputs come straight from these flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state                 <= RSS_IDLE;
      op                    <= RSS_OP_NONE;
      ir                    <= 16'h0000;
      instr_ready           <= 1'b1;
      file_addr             <= 12'h000;
      file_we               <= 1'b0;
      file_wdata            <= 8'h00;
      w_we                  <= 1'b0;
      w_wdata               <= 8'h00;
      indexed_mode          <= 1'b0;
      flag_we               <= 1'b0;
      flag_n                <= 1'b0;
      flag_z                <= 1'b0;
      wdt_clear             <= 1'b0;
      wdt_post_clear        <= 1'b0;
      timeout_status_bit    <= `RSS_TMOUT_RESET;
      power_down_status_bit <= `RSS_PWRDN_RESET;
      sleep_mode            <= 1'b0;
      instr_done            <= 1'b0;
      instr_unknown         <= 1'b0;
    end else begin
      state                 <= next_state;
      op                    <= next_op;
      ir                    <= next_ir;
      instr_ready           <= next_instr_ready;
      file_addr             <= next_file_addr;
      file_we               <= next_file_we;
      file_wdata            <= next_file_wdata;
      w_we                  <= next_w_we;
      w_wdata               <= next_w_wdata;
      indexed_mode          <= next_indexed_mode;
      flag_we               <= next_flag_we;
      flag_n                <= next_flag_n;
      flag_z                <= next_flag_z;
      wdt_clear             <= next_wdt_clear;
      wdt_post_clear        <= next_wdt_post_clear;
      timeout_status_bit    <= next_timeout;
      power_down_status_bit <= next_power_down;
      sleep_mode            <= next_sleep_mode;
      instr_done            <= next_instr_done;
      instr_unknown         <= next_instr_unknown;
    end
  end

endmodule : rss_exec

// ### rss_exec_chk.sv
// Purpose: Port-level checks on rss_exec
// Assumes: One clock domain, async reset high
// Notes:   Bound from the bench top file
`timescale 1ns/100ps
`include "rss_consts.svh"

module rss_exec_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        instr_valid,
  input wire logic [15:0] instr,
  input wire logic        ext_set_en,
  input wire logic [3:0]  bank_select_reg,
  input wire logic [11:0] index_ptr,
  input wire logic [7:0]  file_rdata,
  input wire logic        wake_wdt,
  input wire logic        wake_other,
  input wire logic        instr_ready,
  input wire logic [11:0] file_addr,
  input wire logic        file_we,
  input wire logic [7:0]  file_wdata,
  input wire logic        w_we,
  input wire logic [7:0]  w_wdata,
  input wire logic        indexed_mode,
  input wire logic        flag_we,
  input wire logic        flag_n,
  input wire logic        flag_z,
  input wire logic        wdt_clear,
  input wire logic        wdt_post_clear,
  input wire logic        timeout_status_bit,
  input wire logic        power_down_status_bit,
  input wire logic        sleep_mode,
  input wire logic        instr_done,
  input wire logic        instr_unknown
);
  // ==========================================================
  // Decoded accepts
  logic       acc, rot, fill, slp, byt; // Accept qualifiers
  logic [3:0] abank;                    // Access bank half
  assign acc  = instr_valid && instr_ready;
  assign rot  = acc && ((instr & `RSS_ROT_MASK) == `RSS_ROT_PAT);
  assign fill = acc && ((instr & `RSS_FILL_MASK) == `RSS_FILL_PAT);
  assign slp  = acc && (instr == `RSS_SLEEP_CODE);
  assign byt  = rot || fill;
  assign abank = (instr[7:0] <= `RSS_IDX_LIMIT) ? 4'h0 : 4'hF;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Assertions
  chk_done_two: assert property (acc |=> !instr_ready ##1 instr_done)
    else $error("done not two cycles after accept");
  chk_rot_value: assert property (rot |=> ##1
    (file_we ? file_wdata : w_wdata) == {$past(file_rdata[0]),
    $past(file_rdata[7:1])}) else $error("rotate result wrong");
  chk_rot_dest: assert property (rot |=> ##1
    file_we == $past(instr[9], 2) && w_we != file_we && !instr_unknown)
    else $error("rotate destination wrong");
  chk_rot_flags: assert property (rot |=> ##1 flag_we &&
    flag_n == $past(file_rdata[0]) && flag_z == ($past(file_rdata) == 8'h00))
    else $error("rotate flags wrong");
  chk_bank_addr: assert property (byt && instr[8] |=>
    !indexed_mode && file_addr == {$past(bank_select_reg), $past(instr[7:0])})
    else $error("banked address wrong");
  chk_idx_addr: assert property (byt && !instr[8] && ext_set_en &&
    instr[7:0] <= `RSS_IDX_LIMIT |=> indexed_mode &&
    file_addr == $past(index_ptr) + {4'h0, $past(instr[7:0])})
    else $error("indexed address wrong");
  chk_access_bank: assert property (byt && !instr[8] &&
    !(ext_set_en && instr[7:0] <= `RSS_IDX_LIMIT) |=> !indexed_mode &&
    file_addr == {$past(abank), $past(instr[7:0])})
    else $error("access bank address wrong");
  chk_fill_ones: assert property (fill |=> ##1 file_we &&
    file_wdata == `RSS_ALL_ONES && !flag_we && !w_we)
    else $error("set-file result wrong");
  chk_sleep_entry: assert property (slp |=> ##1 wdt_clear &&
    wdt_post_clear && !power_down_status_bit && timeout_status_bit)
    else $error("sleep status wrong");
  chk_asleep_hold: assert property (sleep_mode && !wake_wdt &&
    !wake_other |=> sleep_mode && !instr_ready)
    else $error("left sleep without wake");
  chk_wdt_wake: assert property (sleep_mode && wake_wdt |=>
    !timeout_status_bit && !sleep_mode) else $error("watchdog wake wrong");

  // Main scenarios reached
  cov_rot: cover property (rot && !instr[9]);
  cov_idx: cover property (fill && !instr[8] && ext_set_en);
  cov_wake: cover property (sleep_mode && wake_wdt);
endmodule : rss_exec_chk

// ### rss_exec_tb_top.sv
// Purpose: Directed bench for rss_exec
// Assumes: Inputs change on falling mclk
// Notes:   Expectations worked out from the instruction rules
`timescale 1ns/100ps
`include "rss_consts.svh"
`define CHK(a,b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected t=%0t got %h exp %h", $time, (a), (b)); end end

module rss_exec_tb_top;
  import rss_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic        mclk = 1'b0, rst = 1'b1, instr_valid = 1'b0;
  logic        ext_set_en = 1'b0, wake_wdt = 1'b0, wake_other = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [3:0]  bank_select_reg = 4'h0;
  logic [11:0] index_ptr = 12'h000, file_addr;
  logic [7:0]  file_rdata = 8'h00, file_wdata, w_wdata;
  logic        instr_ready, file_we, w_we, indexed_mode, flag_we, flag_n;
  logic        flag_z, wdt_clear, wdt_post_clear, timeout_status_bit;
  logic        power_down_status_bit, sleep_mode, instr_done, instr_unknown;
  int          miscompares = 0, n_checks = 0;
  // Ext flag, word, operand byte per case
  logic [24:0] tab [12] = '{{1'b0, 16'h4312, 8'hD7}, {1'b0, 16'h4112, 8'hD7},
    {1'b1, 16'h405F, 8'h00}, {1'b1, 16'h4060, 8'h01},
    {1'b0, 16'h4230, 8'h80}, {1'b1, 16'h4300, 8'hFF},
    {1'b0, 16'h6900, 8'h5A}, {1'b1, 16'h685F, 8'h00},
    {1'b1, 16'h68A0, 8'h00}, {1'b0, 16'h6A00, 8'h00},
    {1'b0, 16'h4400, 8'h00}, {1'b0, 16'h0004, 8'h00}};

  always #10 mclk = ~mclk;

  rss_exec u_dut (.mclk(mclk), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .ext_set_en(ext_set_en), .bank_select_reg(bank_select_reg),
    .index_ptr(index_ptr), .file_rdata(file_rdata), .wake_wdt(wake_wdt),
    .wake_other(wake_other), .instr_ready(instr_ready),
    .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
    .w_we(w_we), .w_wdata(w_wdata), .indexed_mode(indexed_mode),
    .flag_we(flag_we), .flag_n(flag_n), .flag_z(flag_z),
    .wdt_clear(wdt_clear), .wdt_post_clear(wdt_post_clear),
    .timeout_status_bit(timeout_status_bit),
    .power_down_status_bit(power_down_status_bit), .sleep_mode(sleep_mode),
    .instr_done(instr_done), .instr_unknown(instr_unknown));

  // ==========================================================
  // Verdict, reached by tests or watchdog
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // Offer one word, wait for done, compare; entered at a falling edge
  task run_op(input logic [15:0] i, input logic [7:0] rd);
    logic [7:0]  f, r;
    logic [11:0] ea;
    logic        ix, isr, iss;
    logic [5:0]  sts;   // Packed status seen at done
    logic [2:0]  wes;   // Expected write strobes
    logic [7:0]  res;   // Rotated byte at its destination
    f = i[7:0];
    r = {rd[0], rd[7:1]};
    isr = (i & 16'hFC00) == 16'h4000;
    iss = (i & 16'hFE00) == 16'h6800;
    ix = !i[8] && ext_set_en && f <= 8'h5F;
    ea = i[8] ? {bank_select_reg, f} : ix ? index_ptr + {4'h0, f} :
         {(f <= 8'h5F) ? 4'h0 : 4'hF, f};
    instr = i;
    file_rdata = rd;
    instr_valid = 1'b1;
    for (int k = 0; k < 20 && instr_ready !== 1'b1; k++) @(negedge mclk);
    @(negedge mclk);
    instr_valid = 1'b0;
    for (int k = 0; k < 20 && instr_done !== 1'b1; k++) @(negedge mclk);
    `CHK(instr_done, 1'b1)
    if (i == 16'h0003) begin
      sts = {wdt_clear, wdt_post_clear, power_down_status_bit,
             timeout_status_bit, sleep_mode, instr_ready};
      `CHK(sts, 6'b110110)
    end else begin
      `CHK(instr_unknown, !(isr || iss))
      wes = {iss || isr && i[9], isr && !i[9], isr};
      `CHK({file_we, w_we, flag_we}, wes)
      if (isr || iss) begin
        `CHK({indexed_mode, file_addr}, {ix, ea})
      end
      if (isr) begin
        res = i[9] ? file_wdata : w_wdata;
        `CHK({flag_n, flag_z, res}, {r[7], r == 8'h00, r})
      end
      if (iss) `CHK(file_wdata, 8'hFF)
    end
  endtask : run_op

  // Words refused while asleep, then one wake event
  task wake(input logic w, input logic o, input logic exp_to);
    logic [3:0] sts;   // Packed status after the wake edge
    instr = 16'h6900;
    instr_valid = 1'b1;
    repeat (3) begin
      @(negedge mclk);
      `CHK({instr_ready, instr_done, sleep_mode}, 3'b001)
    end
    instr_valid = 1'b0;
    wake_wdt = w;
    wake_other = o;
    @(negedge mclk);
    wake_wdt = 1'b0;
    wake_other = 1'b0;
    sts = {sleep_mode, instr_ready, timeout_status_bit,
           power_down_status_bit};
    `CHK(sts, {2'b01, exp_to, 1'b0})
  endtask : wake

  // ==========================================================
  // Main sequence
  initial begin
    logic [3:0] st;   // Status seen while reset is held
    repeat (8) @(negedge mclk);
    st = {instr_ready, timeout_status_bit, power_down_status_bit,
          sleep_mode};
    `CHK(st, 4'b1110)
    rst = 1'b0;
    for (int k = 0; k < 12; k++) begin
      ext_set_en = tab[k][24];
      bank_select_reg = 4'(k + 3);
      index_ptr = 12'hFA0 + 12'(k);
      run_op(tab[k][23:8], tab[k][7:0]);
    end
    $display("test byte ops done");
    run_op(16'h0003, 8'h00);
    wake(1'b0, 1'b1, 1'b1);
    run_op(16'h0003, 8'h00);
    wake(1'b1, 1'b1, 1'b0);
    // Time-out bit is low here, so this sleep must raise it again
    run_op(16'h0003, 8'h00);
    wake(1'b0, 1'b1, 1'b1);
    run_op(16'h4001, 8'h01);
    $display("test sleep and wake done");
    finish_test();
  end

  // Hang guard, far beyond the 52 or so cycles needed
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
endmodule : rss_exec_tb_top

bind rss_exec rss_exec_chk u_chk (.mclk(mclk), .rst(rst),
  .instr_valid(instr_valid), .instr(instr), .ext_set_en(ext_set_en),
  .bank_select_reg(bank_select_reg), .index_ptr(index_ptr),
  .file_rdata(file_rdata), .wake_wdt(wake_wdt), .wake_other(wake_other),
  .instr_ready(instr_ready), .file_addr(file_addr), .file_we(file_we),
  .file_wdata(file_wdata), .w_we(w_we), .w_wdata(w_wdata),
  .indexed_mode(indexed_mode), .flag_we(flag_we), .flag_n(flag_n),
  .flag_z(flag_z), .wdt_clear(wdt_clear), .wdt_post_clear(wdt_post_clear),
  .timeout_status_bit(timeout_status_bit),
  .power_down_status_bit(power_down_status_bit), .sleep_mode(sleep_mode),
  .instr_done(instr_done), .instr_unknown(instr_unknown));

// ### rss_pkg.sv
// Purpose: Types for the rotate/set/sleep execution block
// Assumes: rss_consts.svh holds the numbers
// Notes:   One-hot state codes written out
package rss_pkg;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    RSS_IDLE  = 3'b001,   // Ready for an instruction
    RSS_EXEC  = 3'b010,   // Operand read, result computed
    RSS_SLEEP = 3'b100    // Core asleep, oscillator stopped
  } rss_state_t;

  // ==========================================================
  // Decoded operation
  typedef enum logic [1:0] {
    RSS_OP_NONE  = 2'h0,  // Not one of ours
    RSS_OP_ROT   = 2'h1,  // Rotate right, no carry
    RSS_OP_FILL  = 2'h2,  // Fill byte with ones
    RSS_OP_SLEEP = 2'h3   // Enter sleep
  } rss_op_t;

endpackage : rss_pkg
